//--- include/cmp_timer_pkg.sv
// package: register map, field layout and constants for the comparator edge counter timer
package cmp_timer_pkg;

  // ==========================================================
  // register indices (printed offsets are not all word aligned)
  localparam logic [11:0] TIMER0_CONTROL_ONE_IDX = 12'hf07;
  localparam logic [11:0] TIMER1_CONTROL_ONE_IDX = 12'hf0f;
  localparam logic [11:0] TIMER_INT_DELAY_IDX = 12'hf08;
  localparam logic [11:0] COUNT_IDX = 12'hf00;
  localparam logic [11:0] RELOAD_IDX = 12'hf02;
  localparam logic [11:0] IRQ_STATUS_IDX = 12'hf10;
  localparam logic [11:0] IRQ_MASK_IDX = 12'hf11;
  localparam logic [11:0] TIMER1_COUNT_IDX = 12'hf12;

  // ==========================================================
  // field positions
  localparam int RUN_ENABLE_BIT = 7;
  localparam int EDGE_POLARITY_BIT = 6;
  localparam int DIVIDER_LSB = 3;
  localparam int MODE_LSB = 0;
  localparam int SOURCE_SEL_LSB = 5;
  localparam int RESERVED_BIT = 4;
  localparam int DELAY_LSB = 1;
  localparam int CAPTURE_FLAG_BIT = 0;

  // ==========================================================
  // reset values and counts
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [6:0] INT_DELAY_RESET = 7'h00;
  localparam int DELAY_CNT_WIDTH = 8;

  // interrupt status bits
  localparam int EV_RELOAD = 0;
  localparam int EV_CAPTURE = 1;
  localparam int EV_OUTPUT = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic run_enable;
    logic edge_polarity;
    logic [2:0] divider;
    logic [2:0] mode;
  } control_one_type;

  typedef struct packed {
    logic [1:0] source_sel;
    logic reserved;
    logic [2:0] delay;
    logic capture_flag;
  } int_delay_type;

  typedef enum logic [1:0] {
    DATA_IDLE,
    DATA_WRITE,
    DATA_READ
  } bus_phase_type;

endpackage : cmp_timer_pkg

//--- src/cmp_edge_detect.sv
// comparator synchroniser and selected-edge detector
`timescale 1ns/1ps
module cmp_edge_detect
  import cmp_timer_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // comparator
  input wire logic i_cmp_out,
  input wire logic i_falling,
  // result
  output logic o_edge,
  output logic o_level
);

  logic sync_first;
  logic sync_second;
  logic sync_prev;

  // ==========================================================
  // two flops, then one more to compare samples
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
      sync_prev <= 1'b0;
    end else if (i_clk_en) begin
      sync_first <= i_cmp_out;
      sync_second <= sync_first;
      sync_prev <= sync_second;
    end
  end

  // only one increment per edge, pulse widths under one clock may vanish
  assign o_edge = i_clk_en & (i_falling ? (sync_prev & ~sync_second)
                                        : (~sync_prev & sync_second));
  assign o_level = sync_second;

endmodule : cmp_edge_detect

//--- src/cmp_assert_delay.sv
// programmable delay before the timer outputs go active
`timescale 1ns/1ps
module cmp_assert_delay
  import cmp_timer_pkg::*;
#(
  parameter int WIDTH = DELAY_CNT_WIDTH
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // control
  input wire logic i_start,
  input wire logic [2:0] i_code,
  // result
  output logic o_fire
);

  logic [WIDTH-1:0] remaining;
  logic busy;
  wire logic [WIDTH:0] span;

  // 2^n clocks, code 000 taken as zero
  function automatic logic [WIDTH:0] delay_span(input logic [2:0] code);
    delay_span = (code == 3'h0) ? '0 : ((WIDTH+1)'(1) << code);
  endfunction : delay_span

  assign span = delay_span(i_code);
  assign o_fire = i_clk_en & ((i_start & (span == '0)) | (busy & (remaining == WIDTH'(1))));

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      remaining <= '0;
      busy <= 1'b0;
    end else if (i_clk_en) begin
      if (i_start && span != '0) begin
        // full 2^n clocks; the widest code must fit in WIDTH bits
        remaining <= WIDTH'(span);
        busy <= 1'b1;
      end else if (busy) begin
        remaining <= remaining - WIDTH'(1);
        busy <= (remaining != WIDTH'(1));
      end
    end
  end

endmodule : cmp_assert_delay

//--- src/cmp_counter_timer.sv
// top: comparator edge counter timer with ahb-lite register slave
//
// Notes on behaviour
// - at reload value: interrupt, restart 0001, continue
// - enabled output pin toggles every reload
// - polarity picks edge and initial output level
// - written start count serves first pass only
// - count rises exactly one per edge
// - bits 6:5 choose interrupt sources
// - bits 3:1 delay outputs 2^n clocks; code 000 gives no delay here
// - bit 0 flags capture-caused last interrupt
// - bit 7 enables counting
// - two control-one registers at f07, f0f
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module cmp_counter_timer
  import cmp_timer_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [13:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // comparator and outputs
  input wire logic i_cmp_out,
  input wire logic i_output_enable,
  output logic o_timer_out,
  output logic o_timer_out_n,
  output logic o_irq
);

  // ==========================================================
  // state
  control_one_type control0;
  control_one_type control1;
  int_delay_type int_delay;
  logic [COUNT_WIDTH-1:0] count;
  logic [COUNT_WIDTH-1:0] reload;
  logic [COUNT_WIDTH-1:0] count1;
  logic [2:0] status;
  logic [2:0] mask;
  logic out_level;
  logic out_active;
  bus_phase_type phase;
  logic [11:0] data_index;
  logic run_prev;

  // ==========================================================
  // bus decode
  wire logic addr_take = i_hsel & i_hready & i_htrans[1] & i_clk_en;
  wire logic [11:0] addr_index = i_haddr[13:2];
  wire logic wr_go = (phase == DATA_WRITE) & i_clk_en;
  wire logic rd_go = (phase == DATA_READ) & i_clk_en;
  wire logic [7:0] wbyte = i_hwdata[7:0];

  function automatic logic hit(input logic [11:0] idx, input logic [11:0] target);
    hit = (idx == target);
  endfunction : hit

  wire logic wr_ctl0 = wr_go & hit(data_index, TIMER0_CONTROL_ONE_IDX);
  wire logic wr_ctl1 = wr_go & hit(data_index, TIMER1_CONTROL_ONE_IDX);
  wire logic wr_intd = wr_go & hit(data_index, TIMER_INT_DELAY_IDX);
  wire logic wr_count = wr_go & hit(data_index, COUNT_IDX);
  wire logic wr_reload = wr_go & hit(data_index, RELOAD_IDX);
  wire logic wr_mask = wr_go & hit(data_index, IRQ_MASK_IDX);
  wire logic wr_count1 = wr_go & hit(data_index, TIMER1_COUNT_IDX);
  wire logic rd_status = rd_go & hit(data_index, IRQ_STATUS_IDX);

  // ==========================================================
  // counting
  logic cmp_edge;
  logic delay_fire;

  cmp_edge_detect u_edge (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_cmp_out(i_cmp_out),
    .i_falling(control0.edge_polarity),
    .o_edge(cmp_edge),
    .o_level()
  );

  wire logic run = control0.run_enable;
  wire logic count_step = run & cmp_edge;
  wire logic reload_hit = count_step & (count == reload);
  wire logic run_start = run & ~run_prev & i_clk_en;
  // second timer has no comparator; it only holds its control and count
  wire logic run1_step = 1'b0;

  cmp_assert_delay #(
    .WIDTH(DELAY_CNT_WIDTH)
  ) u_delay (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_start(run_start),
    .i_code(int_delay.delay),
    .o_fire(delay_fire)
  );

  // interrupt source selection: 0x all, 10 input only, 11 reload only
  wire logic reload_src_ok = ~int_delay.source_sel[1] | int_delay.source_sel[0];
  wire logic input_src_ok = ~int_delay.source_sel[1] | ~int_delay.source_sel[0];
  // counter mode has no capture event; the flag stays in place for other modes
  wire logic capture_event = 1'b0;
  wire logic reload_ev = reload_hit & reload_src_ok;
  wire logic capture_ev = capture_event & input_src_ok;
  wire logic [2:0] event_vec = {delay_fire, capture_ev, reload_ev};
  // a read clears only what it returned, so an event landing between
  // the snapshot and the clear is kept; set wins over the clear
  wire logic [2:0] read_clear = rd_status ? o_hrdata[2:0] : 3'h0;
  wire logic [2:0] next_status = (status & ~read_clear) | event_vec;

  // ==========================================================
  // read select; the word is registered in the address phase
  logic [31:0] early_word;
  always_comb begin
    early_word = 32'h0;
    case (addr_index)
      TIMER0_CONTROL_ONE_IDX: early_word = {24'h0, control0};
      TIMER1_CONTROL_ONE_IDX: early_word = {24'h0, control1};
      TIMER_INT_DELAY_IDX: early_word = {25'h0, int_delay.source_sel, 1'b0,
                                         int_delay.delay, int_delay.capture_flag};
      COUNT_IDX: early_word = {16'h0, count};
      RELOAD_IDX: early_word = {16'h0, reload};
      IRQ_STATUS_IDX: early_word = {29'h0, status};
      IRQ_MASK_IDX: early_word = {29'h0, mask};
      TIMER1_COUNT_IDX: early_word = {16'h0, count1};
      default: early_word = 32'h0;
    endcase
  end

  // ==========================================================
  // bus phase tracking
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      phase <= DATA_IDLE;
      data_index <= 12'h000;
    end else if (i_clk_en && i_hready) begin
      phase <= addr_take ? (i_hwrite ? DATA_WRITE : DATA_READ) : DATA_IDLE;
      data_index <= addr_index;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else if (i_clk_en) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // read data stands until the next read address phase
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_hrdata <= 32'h0;
    end else if (addr_take && !i_hwrite) begin
      o_hrdata <= early_word;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      control0 <= CONTROL_RESET;
    end else if (wr_ctl0) begin
      control0 <= wbyte;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      control1 <= CONTROL_RESET;
    end else if (wr_ctl1) begin
      control1 <= wbyte;
    end
  end

  // reserved bit is not stored, so it always reads back zero
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      int_delay <= INT_DELAY_RESET;
    end else if (i_clk_en) begin
      if (wr_intd) begin
        int_delay.source_sel <= wbyte[SOURCE_SEL_LSB +: 2];
        int_delay.delay <= wbyte[DELAY_LSB +: 3];
      end
      if (reload_ev || capture_ev) begin
        int_delay.capture_flag <= capture_ev;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      mask <= STATUS_RESET;
    end else if (wr_mask) begin
      mask <= wbyte[2:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      reload <= COUNT_WIDTH'(RELOAD_RESET);
    end else if (wr_reload) begin
      reload <= i_hwdata[COUNT_WIDTH-1:0];
    end
  end

  // ==========================================================
  // counter; a count write is ignored while running
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      count <= COUNT_WIDTH'(COUNT_RESTART);
    end else if (i_clk_en) begin
      if (reload_hit) begin
        count <= COUNT_WIDTH'(COUNT_RESTART);
      end else if (count_step) begin
        count <= count + COUNT_WIDTH'(1);
      end else if (wr_count && !run) begin
        count <= i_hwdata[COUNT_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      count1 <= COUNT_WIDTH'(COUNT_RESTART);
    end else if (i_clk_en) begin
      if (wr_count1) begin
        count1 <= i_hwdata[COUNT_WIDTH-1:0];
      end else if (run1_step) begin
        count1 <= count1 + COUNT_WIDTH'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      run_prev <= 1'b0;
    end else if (i_clk_en) begin
      run_prev <= run;
    end
  end

  // ==========================================================
  // timer output
  // pin shows the polarity level until the assert delay has run out
  wire logic shown_level = out_active ? out_level : control0.edge_polarity;
  wire logic pin_level = i_output_enable & shown_level;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      out_level <= 1'b0;
    end else if (i_clk_en) begin
      if (!run) begin
        out_level <= control0.edge_polarity;
      end else if (reload_hit) begin
        out_level <= ~out_level;
      end
    end
  end

  // a late delay after a stop must not wake the output
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      out_active <= 1'b0;
    end else if (i_clk_en) begin
      out_active <= run & (out_active | delay_fire);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_timer_out <= 1'b0;
      o_timer_out_n <= 1'b1;
    end else if (i_clk_en) begin
      o_timer_out <= pin_level;
      o_timer_out_n <= ~pin_level;
    end
  end

  // ==========================================================
  // status and interrupt
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      status <= STATUS_RESET;
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      status <= next_status;
      o_irq <= |(next_status & mask);
    end
  end

endmodule : cmp_counter_timer

//--- verification/cmp_counter_timer_checker.sv
// checker: bus and output relations of the edge counter timer
`timescale 1ns/1ps
module cmp_counter_timer_checker
  import cmp_timer_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // bus
  input wire logic i_hsel,
  input wire logic [13:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // timer
  input wire logic i_cmp_out,
  input wire logic o_timer_out,
  input wire logic o_timer_out_n,
  input wire logic o_irq
);
  // ====
  // helpers
  logic cmp_d;
  logic [7:0] quiet;
  wire acc = i_hsel && i_hready && i_htrans[1] && i_clk_en;
  always_ff @(posedge i_core_clk) cmp_d <= i_cmp_out;
  // window outlasts the longest output delay
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || acc || i_cmp_out != cmp_d) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hff) begin
      quiet <= quiet + 8'h01;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // ====
  // assertions
  reset_outputs_a: assert property (disable iff (1'b0)
    !i_reset_n && i_clk_en |=> !o_irq && !o_timer_out && o_timer_out_n)
    else $error("outputs not at reset level");
  reset_bus_a: assert property (disable iff (1'b0)
    !i_reset_n && i_clk_en |=> o_hreadyout && o_hrdata == 32'h0)
    else $error("bus not idle in reset");
  ready_high_a: assert property (o_hreadyout)
    else $error("bus stalled");
  resp_okay_a: assert property (!o_hresp)
    else $error("bus response not okay");
  unmapped_zero_a: assert property (
    acc && !i_hwrite && i_haddr == 14'h0004 |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    $changed(o_hrdata) |-> $past(acc && !i_hwrite))
    else $error("read data moved without a read");
  irq_drop_a: assert property (
    $fell(o_irq) |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
    else $error("interrupt dropped without bus access");
  quiet_output_a: assert property (
    quiet == 8'hc8 |-> $stable(o_timer_out) && $stable(o_irq))
    else $error("output moved with no cause");
  irq_seen_c: cover property ($rose(o_irq));
  toggle_seen_c: cover property ($changed(o_timer_out));
  unmapped_seen_c: cover property (acc && i_haddr == 14'h0004);
endmodule : cmp_counter_timer_checker

bind cmp_counter_timer cmp_counter_timer_checker u_checker (
  .i_core_clk, .i_reset_n, .i_clk_en, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready,
  .o_hrdata, .o_hreadyout, .o_hresp, .i_cmp_out, .o_timer_out, .o_timer_out_n, .o_irq
);

//--- verification/cmp_source_model.sv
// partner: comparator output that toggles a set number of times
`timescale 1ns/1ps
module cmp_source_model (
  // clock
  input wire logic i_core_clk,
  // request
  input wire logic i_start,
  input wire logic [7:0] i_toggles,
  input wire logic [3:0] i_phase,
  // comparator
  output logic o_cmp,
  output logic o_busy
);
  logic [7:0] left;
  logic [3:0] hold;
  initial begin
    o_cmp = 1'b0;
    left = 8'h00;
    hold = 4'h0;
  end
  // each level lasts i_phase + 1 clocks
  always @(posedge i_core_clk) begin
    if (i_start) begin
      left <= i_toggles;
      hold <= i_phase;
    end else if (left != 8'h00 && hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else if (left != 8'h00) begin
      o_cmp <= ~o_cmp;
      left <= left - 8'h01;
      hold <= i_phase;
    end
  end
  assign o_busy = i_start || left != 8'h00;
endmodule : cmp_source_model

//--- verification/comparator_edge_counter_timer_test.sv
// testbench: registers, counting, polarity and output delay
`timescale 1ns/1ps
module comparator_edge_counter_timer_test
  import cmp_timer_pkg::*;
;
  // ====
  // signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [13:0] haddr = 14'h0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic oen = 1'b1;
  logic [7:0] tog = 8'h00;
  logic [31:0] hrdata;
  logic hready, hresp, cmp, busy, tout, tout_n, irq;
  int errors = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  cmp_counter_timer #(.COUNT_WIDTH(16)) DUT (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_cmp_out(cmp), .i_output_enable(oen), .o_timer_out(tout), .o_timer_out_n(tout_n),
    .o_irq(irq));
  cmp_source_model SRC (.i_core_clk(clk), .i_start(go), .i_toggles(tog), .i_phase(4'h2),
    .o_cmp(cmp), .o_busy(busy));
  // ====
  // shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task bus(input logic [11:0] idx, input logic w, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'b00};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus
  task wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask : wr
  task rdc(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(idx, 1'b0, 32'h0, x);
    chk(x, exp);
  endtask : rdc
  // sync plus compare needs three edges
  task pulse(input logic [7:0] n);
    go <= 1'b1;
    tog <= n;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (5) @(posedge clk);
  endtask : pulse
  // ====
  // scenarios
  task t_reset;
    chk({29'h0, tout, tout_n, irq}, 32'h2);
    rdc(TIMER0_CONTROL_ONE_IDX, 32'h0);
    rdc(TIMER1_CONTROL_ONE_IDX, 32'h0);
    rdc(RELOAD_IDX, {16'h0, RELOAD_RESET});
  endtask : t_reset
  task t_regs;
    wr(TIMER1_CONTROL_ONE_IDX, 32'h7b);
    rdc(TIMER1_CONTROL_ONE_IDX, 32'h7b);
    for (int c = 0; c < 4; c++) begin
      wr(TIMER_INT_DELAY_IDX, 32'(c << 5));
      rdc(TIMER_INT_DELAY_IDX, 32'(c << 5));
    end
    wr(TIMER_INT_DELAY_IDX, 32'hff);
    rdc(TIMER_INT_DELAY_IDX, 32'h6e);
    wr(12'h001, 32'h5a);
    rdc(12'h001, 32'h0);
    wr(TIMER_INT_DELAY_IDX, 32'h0);
  endtask : t_regs
  task t_count;
    logic o;
    logic [31:0] d;
    wr(TIMER0_CONTROL_ONE_IDX, 32'h0);
    wr(COUNT_IDX, 32'h3);
    wr(RELOAD_IDX, 32'h5);
    wr(IRQ_MASK_IDX, 32'h0);
    wr(TIMER0_CONTROL_ONE_IDX, 32'h80);
    pulse(8'h04);
    rdc(COUNT_IDX, 32'h5);
    o = tout;
    pulse(8'h02);
    rdc(COUNT_IDX, 32'h1);
    chk1(tout, ~o);
    chk1(irq, 1'b0);
    wr(IRQ_MASK_IDX, 32'h1);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b1);
    bus(IRQ_STATUS_IDX, 1'b0, 32'h0, d);
    chk(d & 32'h3, 32'h1);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b0);
    pulse(8'h08);
    wr(COUNT_IDX, 32'h9);
    rdc(COUNT_IDX, 32'h5);
    o = tout;
    pulse(8'h02);
    chk1(tout, ~o);
    chk1(irq, 1'b1);
    bus(IRQ_STATUS_IDX, 1'b0, 32'h0, d);
    wr(TIMER_INT_DELAY_IDX, 32'h40);
    pulse(8'h0a);
    rdc(IRQ_STATUS_IDX, 32'h0);
    wr(TIMER_INT_DELAY_IDX, 32'h0);
    wr(TIMER0_CONTROL_ONE_IDX, 32'h0);
    pulse(8'h04);
    rdc(COUNT_IDX, 32'h1);
    wr(IRQ_MASK_IDX, 32'h0);
    bus(IRQ_STATUS_IDX, 1'b0, 32'h0, d);
  endtask : t_count
  task t_polarity;
    wr(TIMER0_CONTROL_ONE_IDX, 32'h40);
    repeat (2) @(posedge clk);
    chk1(tout, 1'b1);
    oen <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, tout, tout_n}, 32'h1);
    oen <= 1'b1;
    wr(COUNT_IDX, 32'h1);
    wr(RELOAD_IDX, 32'hffff);
    wr(TIMER0_CONTROL_ONE_IDX, 32'hc0);
    pulse(8'h01);
    rdc(COUNT_IDX, 32'h1);
    pulse(8'h01);
    rdc(COUNT_IDX, 32'h2);
  endtask : t_polarity
  task t_delay;
    int t[8];
    logic [31:0] d;
    for (int c = 0; c < 8; c++) begin
      wr(TIMER0_CONTROL_ONE_IDX, 32'h0);
      wr(TIMER_INT_DELAY_IDX, 32'(c << 1));
      bus(IRQ_STATUS_IDX, 1'b0, 32'h0, d);
      wr(IRQ_MASK_IDX, 32'h4);
      wr(TIMER0_CONTROL_ONE_IDX, 32'h80);
      t[c] = 0;
      while (irq !== 1'b1 && t[c] < 400) begin
        @(posedge clk);
        t[c]++;
      end
      chk(32'(t[c] - t[0]), (c == 0) ? 32'h0 : 32'h1 << c);
    end
    wr(IRQ_MASK_IDX, 32'h0);
  endtask : t_delay
  task end_sim;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // ====
  // sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_regs;
    t_count;
    t_polarity;
    t_delay;
    // idle window lets the quiet-output check run
    repeat (210) @(posedge clk);
    end_sim;
  end
  initial begin
    repeat (10000) @(posedge clk);
    errors++;
    end_sim;
  end
endmodule : comparator_edge_counter_timer_test
